/* File: pci_tgt_pkg.sv */
/*
 * Shared constants and carrier types for the single-data-phase PCI target.
 * Assumes every PCI pin is already synchronous to the PCI clock.
 */
package pci_tgt_pkg;

   // ==========================================================
   // Bus widths
   localparam int AD_W = 32;
   localparam int CBE_W = 4;

   // ==========================================================
   // Bus commands on C/BE# during the address phase
   localparam logic [3:0] CMD_IO_RD = 4'h2;
   localparam logic [3:0] CMD_IO_WR = 4'h3;
   localparam logic [3:0] CMD_MEM_RD = 4'h6;
   localparam logic [3:0] CMD_MEM_WR = 4'h7;
   localparam logic [3:0] CMD_CFG_RD = 4'ha;
   localparam logic [3:0] CMD_CFG_WR = 4'hb;

   // ==========================================================
   // Low address patterns for the byte-enable check
   localparam logic [1:0] LANE_B0 = 2'h0;
   localparam logic [1:0] LANE_B1 = 2'h1;
   localparam logic [1:0] LANE_B2 = 2'h2;

   // ==========================================================
   // Reset values of driven pins
   localparam logic DEASSERT_B = 1'b1;
   localparam logic [AD_W-1:0] AD_RESET = 32'h0000_0000;

   // ==========================================================
   // Target sequencer states, Gray coded in the order listed
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_DECODE = 3'h1,
      ST_RDWAIT = 3'h3,
      ST_XFER = 3'h2,
      ST_STOP = 3'h6,
      ST_ABORT = 3'h7,
      ST_TURN = 3'h5
   } tgt_state_e;

   // ==========================================================
   // Pins driven by the master
   typedef struct packed {
      logic frame_b;
      logic irdy_b;
      logic idsel;
      logic [AD_W-1:0] ad;
      logic [CBE_W-1:0] cbe_b;
      logic par;
   } pci_in_s;

   // ==========================================================
   // Access handed to the register back end
   typedef struct packed {
      logic valid;
      logic write;
      logic cfg;
      logic [3:0] cmd;
      logic [AD_W-1:0] addr;
      logic [CBE_W-1:0] be_b;
      logic [AD_W-1:0] data;
   } acc_req_s;

endpackage : pci_tgt_pkg

/* File: pci_even_parity.sv */
/*
 * Even-parity bit over address/data and command/byte-enable lines.
 * Pure combinational; caller registers the result where timing needs it.
 */
`timescale 1ns/1ps
module pci_even_parity #(
   parameter int W = 36
) (
   // Covered lines
   input wire logic [W-1:0] i_bits,
   // Bit that makes the total count of ones even
   output logic o_par
);
   // ==========================================================
   // Fold
   logic [W-1:0] fold;
   genvar g;
   assign fold[0] = i_bits[0];
   generate
      for (g = 1; g < W; g++)
      begin : g_fold
         assign fold[g] = fold[g-1] ^ i_bits[g];
      end
   endgenerate
   assign o_par = fold[W-1];
endmodule : pci_even_parity

/* File: pci_be_check.sv */
/*
 * Legal pairing of low address bits with byte enables for I/O accesses.
 * Assumes byte enables are the active-low data-phase values.
 */
`timescale 1ns/1ps
module pci_be_check (
   // Address phase low bits and data phase enables
   input wire logic [1:0] i_addr_lo,
   input wire logic [pci_tgt_pkg::CBE_W-1:0] i_be_b,
   // Combination is allowed
   output logic o_ok
);
   import pci_tgt_pkg::*;

   // ==========================================================
   // Lane table
   always_comb
   begin
      case (i_addr_lo)
         LANE_B0: o_ok = ~i_be_b[0];
         LANE_B1: o_ok = ~i_be_b[1] & i_be_b[0];
         LANE_B2: o_ok = ~i_be_b[2] & (&i_be_b[1:0]);
         default: o_ok = 1'b0;
      endcase
   end
endmodule : pci_be_check

/* File: pci_target.sv */
/*
 * PCI target with one data phase per transaction, disconnect of bursts,
 * target abort on address parity or lane errors, and even parity.
 * Assumes PCI pins are synchronous to i_mclk and the back end answers a read
 * combinationally in the cycle its request is shown.
 */
// Function
// [R01] IDSEL with a configuration command during address phase selects configuration space.
// [R02] Target only; no request or grant logic, never masters the bus.
// [R03] Burst: finish first data phase, assert STOP while FRAME held, no more data.
// [R04] Master restarts a fresh transaction for data left after disconnect.
// [R05] Target abort drops DEVSEL in the same clock STOP asserts.
// [R06] Before abort, DEVSEL held one clock with TRDY deasserted.
// [R07] Address parity failure gives target abort and internal system error pulse.
// [R08] I/O low address bits must pair with byte enables, else abort without data.
// [R09] Back-to-back transactions accepted without idle when no signal contention.
// [R10] One idle removed after a write to the same target is tolerated.
// [R11] PAR driven clock after covered data; parity error flagged one clock after PAR.
// [R12] Even parity over AD, C/BE and PAR.
// [R13] Same parity handling for every transaction type, configuration included.
// [R14] Only one data phase per transaction; continuation gets retry disconnect.
// [R15] Data moves only on edges with IRDY and TRDY both asserted.
// [R16] STOP held until FRAME deasserts, then STOP and DEVSEL released, back to idle.
`timescale 1ns/1ps
module pci_target (
   // Clock, reset, enable
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   // Master-driven pins
   input wire pci_tgt_pkg::pci_in_s i_pci,
   // Back end address decode, looked at in the address phase
   input wire logic i_claim,
   // Back end read data for the request shown on o_req
   input wire logic [pci_tgt_pkg::AD_W-1:0] i_rdata,
   // Target-driven pins, enables low while driving
   output logic [pci_tgt_pkg::AD_W-1:0] o_ad,
   output logic o_ad_oe_b,
   output logic o_par,
   output logic o_par_oe_b,
   output logic o_trdy_b,
   output logic o_devsel_b,
   output logic o_stop_b,
   output logic o_ctl_oe_b,
   // Internal error pulses
   output logic o_perr,
   output logic o_serr,
   // Access to the back end
   output pci_tgt_pkg::acc_req_s o_req
);
   import pci_tgt_pkg::*;

   // ==========================================================
   // State
   tgt_state_e state_reg, state_next;
   logic [AD_W-1:0] ad_reg, ad_next;
   logic ad_oe_b_reg, ad_oe_b_next;
   logic par_reg, par_next;
   logic par_oe_b_reg, par_oe_b_next;
   logic trdy_b_reg, trdy_b_next;
   logic devsel_b_reg, devsel_b_next;
   logic stop_b_reg, stop_b_next;
   logic ctl_oe_b_reg, ctl_oe_b_next;
   logic perr_reg, perr_next;
   logic serr_reg, serr_next;
   acc_req_s req_reg, req_next;
   logic [AD_W-1:0] cap_ad_reg, cap_ad_next;
   logic [CBE_W-1:0] cap_cbe_reg, cap_cbe_next;
   logic dchk_reg, dchk_next;
   logic [3:0] cmd_reg, cmd_next;
   logic cfg_reg, cfg_next;

   // ==========================================================
   // Helpers
   logic cap_par;
   logic drv_par;
   logic be_ok;
   logic addr_phase;
   logic is_cfg;
   logic is_io;
   logic is_write;
   logic xfer;

   pci_even_parity #(.W(AD_W + CBE_W)) u_cap_par (
      .i_bits({cap_ad_reg, cap_cbe_reg}),
      .o_par(cap_par)
   );

   pci_even_parity #(.W(AD_W + CBE_W)) u_drv_par (
      .i_bits({ad_reg, i_pci.cbe_b}),
      .o_par(drv_par)
   );

   pci_be_check u_be (
      .i_addr_lo(cap_ad_reg[1:0]),
      .i_be_b(i_pci.cbe_b),
      .o_ok(be_ok)
   );

   // New address phase: FRAME asserted while IRDY still idle
   assign addr_phase = ~i_pci.frame_b & i_pci.irdy_b;
   assign is_cfg = i_pci.idsel & ((i_pci.cbe_b == CMD_CFG_RD) | (i_pci.cbe_b == CMD_CFG_WR));
   assign is_io = (cmd_reg == CMD_IO_RD) | (cmd_reg == CMD_IO_WR);
   // Odd commands are writes for every command this target claims
   assign is_write = cmd_reg[0];
   assign xfer = ~i_pci.irdy_b & ~trdy_b_reg; // [R15]

   // ==========================================================
   // Next state
   always_comb
   begin
      state_next = state_reg;
      ad_next = ad_reg;
      ad_oe_b_next = ad_oe_b_reg;
      trdy_b_next = trdy_b_reg;
      devsel_b_next = devsel_b_reg;
      stop_b_next = stop_b_reg;
      ctl_oe_b_next = ctl_oe_b_reg;
      serr_next = 1'b0;
      perr_next = 1'b0;
      req_next = req_reg;
      req_next.valid = 1'b0;
      cap_ad_next = cap_ad_reg;
      cap_cbe_next = cap_cbe_reg;
      dchk_next = 1'b0;
      cmd_next = cmd_reg;
      cfg_next = cfg_reg;

      // Read data parity follows the data one clock later
      par_next = drv_par; // [R11] [R12] [R13]
      par_oe_b_next = ad_oe_b_reg; // [R11]

      // Write data parity checked against PAR of the next clock
      if (dchk_reg)
      begin
         perr_next = cap_par ^ i_pci.par; // [R11] [R12] [R13]
      end

      case (state_reg)
         ST_IDLE, ST_TURN:
         begin
            // Pins driven high for a cycle before release
            trdy_b_next = DEASSERT_B;
            devsel_b_next = DEASSERT_B;
            stop_b_next = DEASSERT_B;
            ctl_oe_b_next = DEASSERT_B;
            ad_oe_b_next = DEASSERT_B;
            state_next = ST_IDLE;
            // Fast back-to-back start taken straight from turnaround
            if (addr_phase && (is_cfg || (i_claim && !i_pci.idsel))) // [R01] [R09] [R10]
            begin
               cap_ad_next = i_pci.ad;
               cap_cbe_next = i_pci.cbe_b;
               cmd_next = i_pci.cbe_b;
               cfg_next = is_cfg; // [R01]
               devsel_b_next = 1'b0;
               ctl_oe_b_next = 1'b0;
               state_next = ST_DECODE;
            end
         end

         ST_DECODE:
         begin
            // DEVSEL low with TRDY high this clock before any abort
            if ((cap_par ^ i_pci.par) || (is_io && !be_ok)) // [R06] [R07] [R08]
            begin
               serr_next = cap_par ^ i_pci.par; // [R07] [R12]
               devsel_b_next = DEASSERT_B; // [R05]
               stop_b_next = 1'b0; // [R05]
               state_next = ST_ABORT;
            end
            else
            begin
               req_next.write = is_write;
               req_next.cfg = cfg_reg;
               req_next.cmd = cmd_reg;
               req_next.addr = cap_ad_reg;
               req_next.be_b = i_pci.cbe_b;
               if (is_write)
               begin
                  trdy_b_next = 1'b0;
                  state_next = ST_XFER;
               end
               else
               begin
                  req_next.valid = 1'b1;
                  state_next = ST_RDWAIT;
               end
            end
         end

         ST_RDWAIT:
         begin
            ad_next = i_rdata;
            ad_oe_b_next = 1'b0;
            trdy_b_next = 1'b0;
            state_next = ST_XFER;
         end

         ST_XFER:
         begin
            if (xfer)
            begin
               trdy_b_next = DEASSERT_B;
               if (is_write)
               begin
                  req_next.valid = 1'b1;
                  req_next.data = i_pci.ad;
                  req_next.be_b = i_pci.cbe_b;
                  cap_ad_next = i_pci.ad;
                  cap_cbe_next = i_pci.cbe_b;
                  dchk_next = 1'b1;
               end
               if (!i_pci.frame_b)
               begin
                  // Master wants more; one data phase only
                  stop_b_next = 1'b0; // [R03] [R14]
                  state_next = ST_STOP;
               end
               else
               begin
                  devsel_b_next = DEASSERT_B;
                  ad_oe_b_next = DEASSERT_B;
                  state_next = ST_TURN;
               end
            end
         end

         ST_STOP, ST_ABORT:
         begin
            // No TRDY while STOP is out, so nothing more moves
            trdy_b_next = DEASSERT_B; // [R03]
            ad_oe_b_next = DEASSERT_B;
            if (i_pci.frame_b)
            begin
               stop_b_next = DEASSERT_B; // [R16]
               devsel_b_next = DEASSERT_B; // [R16]
               state_next = ST_TURN;
            end
         end

         default:
         begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // ==========================================================
   // Registers; no bus request pin exists, so the target never masters
   always_ff @(posedge i_mclk or negedge i_rst_b) // [R02]
   begin
      if (!i_rst_b)
      begin
         state_reg <= ST_IDLE;
         ad_reg <= AD_RESET;
         ad_oe_b_reg <= DEASSERT_B;
         par_reg <= 1'b0;
         par_oe_b_reg <= DEASSERT_B;
         trdy_b_reg <= DEASSERT_B;
         devsel_b_reg <= DEASSERT_B;
         stop_b_reg <= DEASSERT_B;
         ctl_oe_b_reg <= DEASSERT_B;
         perr_reg <= 1'b0;
         serr_reg <= 1'b0;
         req_reg <= '0;
         cap_ad_reg <= AD_RESET;
         cap_cbe_reg <= '0;
         dchk_reg <= 1'b0;
         cmd_reg <= '0;
         cfg_reg <= 1'b0;
      end
      else if (i_ce)
      begin
         state_reg <= state_next;
         ad_reg <= ad_next;
         ad_oe_b_reg <= ad_oe_b_next;
         par_reg <= par_next;
         par_oe_b_reg <= par_oe_b_next;
         trdy_b_reg <= trdy_b_next;
         devsel_b_reg <= devsel_b_next;
         stop_b_reg <= stop_b_next;
         ctl_oe_b_reg <= ctl_oe_b_next;
         perr_reg <= perr_next;
         serr_reg <= serr_next;
         req_reg <= req_next;
         cap_ad_reg <= cap_ad_next;
         cap_cbe_reg <= cap_cbe_next;
         dchk_reg <= dchk_next;
         cmd_reg <= cmd_next;
         cfg_reg <= cfg_next;
      end
   end

   // ==========================================================
   // Outputs
   assign o_ad = ad_reg;
   assign o_ad_oe_b = ad_oe_b_reg;
   assign o_par = par_reg;
   assign o_par_oe_b = par_oe_b_reg;
   assign o_trdy_b = trdy_b_reg;
   assign o_devsel_b = devsel_b_reg;
   assign o_stop_b = stop_b_reg;
   assign o_ctl_oe_b = ctl_oe_b_reg;
   assign o_perr = perr_reg;
   assign o_serr = serr_reg;
   assign o_req = req_reg;

endmodule : pci_target

/* File: pci_target_assertions.sv */
/*
 * Port checker for pci_target, bound to every instance.
 * Assumes the PCI clock and active-low reset of that instance.
 */
`timescale 1ns/1ps
module pci_target_checker (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // Watched ports
   input wire pci_tgt_pkg::pci_in_s i_pci,
   input wire logic [pci_tgt_pkg::AD_W-1:0] o_ad,
   input wire logic o_ad_oe_b,
   input wire logic o_par,
   input wire logic o_par_oe_b,
   input wire logic o_trdy_b,
   input wire logic o_devsel_b,
   input wire logic o_stop_b,
   input wire logic o_ctl_oe_b,
   input wire logic o_perr,
   input wire logic o_serr,
   input wire pci_tgt_pkg::acc_req_s o_req
);
   import pci_tgt_pkg::*;
   // ==========
   // Termination
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_b);
   abort_drop_devsel_a:
      assert property ($fell(o_stop_b) && o_devsel_b |-> $rose(o_devsel_b))
      else $error("Abort kept devsel");
   abort_wait_a:
      assert property ($fell(o_stop_b) && o_devsel_b |-> !$past(o_devsel_b) && $past(o_trdy_b))
      else $error("Abort without wait phase");
   addr_par_abort_a:
      assert property (o_serr |-> $fell(o_stop_b) && o_devsel_b)
      else $error("Serr without abort");
   burst_stop_a:
      assert property (!o_trdy_b && !i_pci.irdy_b && !i_pci.frame_b
         |=> !o_stop_b && o_trdy_b && !o_devsel_b)
      else $error("Burst not disconnected");
   one_phase_a:
      assert property (!o_trdy_b && !i_pci.irdy_b |=> o_trdy_b [*2])
      else $error("Second data phase");
   write_xfer_a:
      assert property (o_req.valid && o_req.write |-> !$past(o_trdy_b) && !$past(i_pci.irdy_b))
      else $error("Write without transfer");
   stop_hold_a:
      assert property (!o_stop_b && !i_pci.frame_b |=> !o_stop_b)
      else $error("Stop dropped early");
   stop_release_a:
      assert property (!o_stop_b && i_pci.frame_b |=> o_stop_b && o_devsel_b)
      else $error("Stop stuck");
   // ==========
   // Control pin drive
   ctl_drive_a:
      assert property ((!o_devsel_b || !o_stop_b || !o_trdy_b) |-> !o_ctl_oe_b)
      else $error("Control pins not driven");
   ctl_release_a:
      assert property ($rose(o_ctl_oe_b) |-> $past(o_devsel_b) && $past(o_stop_b)
         && $past(o_trdy_b))
      else $error("Control released while low");
   // ==========
   // Parity
   read_par_a:
      assert property (!o_ad_oe_b |=> !o_par_oe_b
         && o_par == ((^$past(o_ad)) ^ (^$past(i_pci.cbe_b))))
      else $error("Bad read parity");
   perr_flag_a:
      assert property (o_req.valid && o_req.write |=> o_perr == ((^$past(o_req.data))
         ^ (^$past(o_req.be_b)) ^ $past(i_pci.par)))
      else $error("Bad perr");
endmodule : pci_target_checker

bind pci_target pci_target_checker u_chk (.i_mclk, .i_rst_b, .i_pci, .o_ad, .o_ad_oe_b, .o_par,
   .o_par_oe_b, .o_trdy_b, .o_devsel_b, .o_stop_b, .o_ctl_oe_b, .o_perr, .o_serr, .o_req);

/* File: pci_master_model.sv */
/*
 * Behavioural PCI master, one transaction at a time.
 * Assumes the bench resolves AD and PAR from both drivers.
 */
`timescale 1ns/1ps
module pci_master_model (
   // Clock
   input wire logic i_mclk,
   // Target pins as seen on the bus
   input wire logic i_trdy_b,
   input wire logic i_devsel_b,
   input wire logic i_stop_b,
   input wire logic [pci_tgt_pkg::AD_W-1:0] i_ad,
   // Master pins
   output pci_tgt_pkg::pci_in_s o_pci
);
   import pci_tgt_pkg::*;
   pci_in_s bus = '{frame_b: 1'b1, irdy_b: 1'b1, default: '0};
   logic ppar = 1'b0;
   assign o_pci = bus;
   // ==========
   // Bus cycles, pins move on falling edges
   task automatic idle();
      @(negedge i_mclk);
      bus.frame_b = 1'b1;
      bus.irdy_b = 1'b1;
      bus.idsel = 1'b0;
      bus.ad = ~bus.ad; // Released lines must not keep old data
      bus.par = ppar;
   endtask : idle
   // Codes: 0 data, 1 disconnect, 2 abort, 3 no answer; opt: burst, bad addr par, bad data par
   task automatic txn(input logic [3:0] cmd, input logic [31:0] adr, input logic [31:0] dat,
         input logic [3:0] be, input logic cfg, input logic [2:0] opt,
         output logic [31:0] rd, output logic [1:0] how);
      @(negedge i_mclk);
      bus = '{frame_b: 1'b0, irdy_b: 1'b1, idsel: cfg, ad: adr, cbe_b: cmd, par: ppar};
      @(negedge i_mclk);
      bus = '{frame_b: ~opt[0], irdy_b: 1'b0, idsel: 1'b0, ad: cmd[0] ? dat : ~adr, cbe_b: be,
         par: (^{adr, cmd}) ^ opt[1]};
      ppar = (^{dat, be}) ^ opt[2];
      how = 2'h3;
      rd = '0;
      for (int n = 0; n < 16 && how == 2'h3; n++)
      begin
         @(posedge i_mclk);
         if (!i_trdy_b)
         begin
            how = 2'h0;
            rd = i_ad;
         end
         else if (!i_stop_b)
            how = i_devsel_b ? 2'h2 : 2'h1;
      end
      if (opt[0] && how == 2'h0)
      begin
         @(negedge i_mclk);
         bus.irdy_b = 1'b1;
         bus.par = ppar;
         @(posedge i_mclk);
         how = (!i_stop_b && !i_devsel_b) ? 2'h1 : 2'h3;
      end
      if (how != 2'h0)
      begin
         @(negedge i_mclk);
         bus.frame_b = 1'b1;
         bus.irdy_b = 1'b1;
      end
   endtask : txn
endmodule : pci_master_model

/* File: pci_target_termination_parity_tb_top.sv */
/*
 * Self-checking bench for pci_target with a behavioural master.
 * Assumes the checker is bound from its own file.
 */
`timescale 1ns/1ps
module pci_target_termination_parity_tb_top;
   import pci_tgt_pkg::*;
   // ==========
   // Clock, reset and bus wires
   logic i_mclk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_claim = 1'b0;
   logic [AD_W-1:0] i_rdata = '0;
   pci_in_s pci_m;
   pci_in_s pci;
   logic [AD_W-1:0] o_ad;
   logic o_ad_oe_b, o_par, o_par_oe_b, o_trdy_b, o_devsel_b, o_stop_b, o_ctl_oe_b, o_perr, o_serr;
   acc_req_s o_req;
   acc_req_s last_req = '0;
   int n_errors = 0;
   int comparisons = 0;
   int n_req = 0;
   int n_perr = 0;
   int n_serr = 0;
   logic [31:0] rd;
   logic [1:0] how;
   always #10 i_mclk = ~i_mclk;
   always_comb
   begin
      pci = pci_m;
      if (!o_ad_oe_b)
         pci.ad = o_ad;
      if (!o_par_oe_b)
         pci.par = o_par;
   end
   pci_target u_dut (.i_mclk, .i_rst_b, .i_ce(1'b1), .i_pci(pci), .i_claim, .i_rdata, .o_ad,
      .o_ad_oe_b, .o_par, .o_par_oe_b, .o_trdy_b, .o_devsel_b, .o_stop_b, .o_ctl_oe_b, .o_perr,
      .o_serr, .o_req);
   pci_master_model u_master (.i_mclk, .i_trdy_b(o_trdy_b), .i_devsel_b(o_devsel_b),
      .i_stop_b(o_stop_b), .i_ad(pci.ad), .o_pci(pci_m));
   // Back end answers from the shown request, counted mid-cycle to dodge edge races
   always @(negedge i_mclk)
   begin
      i_rdata <= o_req.addr ^ 32'ha5a5_0f0f;
      if (o_req.valid === 1'b1)
      begin
         last_req = o_req;
         n_req++;
      end
      if (o_perr === 1'b1)
         n_perr++;
      if (o_serr === 1'b1)
         n_serr++;
   end
   // ==========
   // Helpers
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : check
   task automatic settle();
      repeat (3) u_master.idle();
   endtask : settle
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : final_report
   // ==========
   // Scenarios
   task automatic t_reset();
      @(negedge i_mclk);
      check({o_ad, o_par, o_trdy_b, o_devsel_b, o_stop_b, o_ctl_oe_b}, {33'h0, 4'hf});
      check({o_ad_oe_b, o_par_oe_b, o_perr, o_serr, o_req.valid}, 5'h18);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_basic();
      int n0;
      n0 = n_req;
      u_master.txn(CMD_IO_WR, 32'h0000_0104, 32'hdead_beef, 4'h0, 1'b0, 3'h0, rd, how);
      u_master.txn(CMD_IO_RD, 32'h0000_0104, '0, 4'h0, 1'b0, 3'h0, rd, how);
      check({how, rd}, {2'h0, 32'ha5a5_0e0b});
      u_master.txn(CMD_CFG_WR, 32'h0000_0040, 32'h1234_5678, 4'h0, 1'b1, 3'h0, rd, how);
      u_master.txn(CMD_CFG_RD, 32'h0000_0040, '0, 4'h0, 1'b1, 3'h0, rd, how);
      check(rd, 32'ha5a5_0f4f);
      settle();
      check(n_req - n0, 4);
      check({last_req.cfg, last_req.write, last_req.addr}, {2'h2, 32'h0000_0040});
      check(last_req.cmd, CMD_CFG_RD);
      $display("t_basic done");
   endtask : t_basic
   task automatic t_lane();
      logic [6:0] tab [6];
      int n0;
      tab = '{7'h1d, 7'h3b, 7'h57, 7'h60, 7'h38, 7'h02};
      n0 = n_req;
      for (int i = 0; i < 6; i++)
      begin
         u_master.txn(CMD_IO_WR, {30'h80, tab[i][6:5]}, 32'h5, tab[i][4:1], 1'b0, 3'h0, rd, how);
         check(how, tab[i][0] ? 2'h0 : 2'h2);
      end
      settle();
      check(n_req - n0, 3);
      check(last_req.be_b, 4'hb);
      $display("t_lane done");
   endtask : t_lane
   task automatic t_apar();
      int n0;
      int s0;
      n0 = n_req;
      s0 = n_serr;
      u_master.txn(CMD_IO_RD, 32'h0000_0100, '0, 4'h0, 1'b0, 3'h2, rd, how);
      check(how, 2'h2);
      u_master.txn(CMD_CFG_WR, 32'h0000_0044, 32'h0, 4'h0, 1'b1, 3'h2, rd, how);
      check(how, 2'h2);
      settle();
      check({n_serr - s0, n_req - n0}, {32'h2, 32'h0});
      $display("t_apar done");
   endtask : t_apar
   task automatic t_burst();
      int n0;
      n0 = n_req;
      u_master.txn(CMD_MEM_WR, 32'h0000_2000, 32'h0bad_f00d, 4'h0, 1'b0, 3'h1, rd, how);
      check(how, 2'h1);
      settle();
      check(last_req.data, 32'h0bad_f00d);
      u_master.txn(CMD_MEM_RD, 32'h0000_2000, '0, 4'h0, 1'b0, 3'h1, rd, how);
      check({how, rd}, {2'h1, 32'ha5a5_2f0f});
      settle();
      check(n_req - n0, 2);
      $display("t_burst done");
   endtask : t_burst
   task automatic t_dpar();
      int p0;
      p0 = n_perr;
      u_master.txn(CMD_CFG_WR, 32'h0000_0048, 32'h0000_0001, 4'h0, 1'b1, 3'h4, rd, how);
      u_master.txn(CMD_IO_WR, 32'h0000_0108, 32'h0000_0003, 4'h0, 1'b0, 3'h0, rd, how);
      settle();
      check(n_perr - p0, 1);
      $display("t_dpar done");
   endtask : t_dpar
   task automatic t_refuse();
      u_master.idle();
      i_claim = 1'b0;
      u_master.txn(CMD_IO_RD, 32'h0000_0300, '0, 4'h0, 1'b0, 3'h0, rd, how);
      check(how, 2'h3);
      u_master.txn(CMD_CFG_RD, 32'h0000_004c, '0, 4'h0, 1'b1, 3'h0, rd, how);
      check({how, rd}, {2'h0, 32'ha5a5_0f43});
      u_master.idle();
      i_claim = 1'b1;
      u_master.txn(CMD_IO_RD, 32'h0000_0300, '0, 4'h0, 1'b1, 3'h0, rd, how);
      check(how, 2'h3);
      u_master.idle();
      $display("t_refuse done");
   endtask : t_refuse
   initial
   begin
      repeat (3) @(posedge i_mclk);
      @(negedge i_mclk);
      i_rst_b = 1'b1;
      i_claim = 1'b1;
      t_reset();
      t_basic();
      t_lane();
      t_apar();
      t_burst();
      t_dpar();
      t_refuse();
      final_report();
   end
   // Watchdog, about twenty-four times the expected run
   initial
   begin
      #60000;
      n_errors++;
      final_report();
   end
endmodule : pci_target_termination_parity_tb_top
